// >>> rtl/asp_map.vh
`ifndef ASP_MAP_VH
`define ASP_MAP_VH

// Shared pin positions within the six-pin group (pin order 8..13)
`define ASP_PIN_FRAME 0
`define ASP_PIN_RDERR 1
`define ASP_PIN_CFGSRC 2
`define ASP_PIN_CFGDIN 3
`define ASP_PIN_CFGCLK 4
`define ASP_PIN_CFGSEL 5

// Result bits carried on the shared pins in parallel mode
`define ASP_RESULT_LO 8
`define ASP_RESULT_HI 13
`define ASP_RESULT_W 14
`define ASP_SHARED_W 6

// Serial configuration register
`define ASP_CFG_W 8
`define ASP_CFG_RESET 8'h00

// Hardware configuration pins (range and mode)
`define ASP_HWCFG_W 8

// Synchroniser depth in flip-flops
`define ASP_SYNC_STAGES 2

// Cycles after the shared-pin drivers let go before config clock edges may write the serial register
`define ASP_SETTLE_CYCLES 2'h3

`endif

// >>> rtl/asp_sync.v
`timescale 1ns/1ps
`include "asp_map.vh"

module asp_sync #(
    parameter W = 1
) (
    input wire i_clock,
    input wire i_reset,
    input wire [W-1:0] i_async,
    output reg [W-1:0] o_sync
);

    reg [W-1:0] meta_q;

    // Two flops; the first is read only by the second
    always @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            meta_q <= {W{1'b0}};
            o_sync <= {W{1'b0}};
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule // asp_sync

// >>> rtl/asp_serial_port.v
`timescale 1ns/1ps
`include "asp_map.vh"

module asp_serial_port #(
    parameter CFG_W = `ASP_CFG_W,
    parameter HWCFG_W = `ASP_HWCFG_W
) (
    input wire i_clock,
    input wire i_reset,
    input wire i_interface_type_select,
    input wire i_data_clock_source_select,
    input wire i_clock_edge_invert,
    input wire i_frame_marker_polarity,
    input wire [HWCFG_W-1:0] i_hw_config,
    input wire [`ASP_SHARED_W-1:0] i_shared_pin,
    input wire [`ASP_RESULT_W-1:0] i_result,
    input wire i_read_start,
    input wire i_read_valid,
    input wire i_read_complete,
    input wire i_conversion_done,
    output reg [`ASP_SHARED_W-1:0] o_shared_pin,
    output reg [`ASP_SHARED_W-1:0] o_shared_oe,
    output reg o_serial_mode,
    output reg o_master_mode,
    output reg o_falling_edge_mode,
    output reg [CFG_W-1:0] o_config_register,
    output reg [HWCFG_W-1:0] o_active_config,
    output reg o_hw_config_active,
    output reg o_result_discard
);

    localparam SYNC_W = 4 + HWCFG_W + `ASP_SHARED_W;

    wire [SYNC_W-1:0] sync_in;
    wire [SYNC_W-1:0] sync_out;
    wire serial_s;
    wire slave_s;
    wire invert_s;
    wire polarity_s;
    wire [HWCFG_W-1:0] hw_cfg_s;
    wire [`ASP_SHARED_W-1:0] pin_s;
    wire cfg_src_s;
    wire cfg_din_s;
    wire cfg_clk_s;
    wire cfg_sel_n_s;

    reg cfg_clk_prev_q;
    reg [1:0] settle_q;
    reg cfg_edge;
    reg cfg_write_en;
    reg [CFG_W-1:0] cfg_q;
    reg read_open_q;
    reg rderr_d;
    reg [`ASP_SHARED_W-1:0] pin_d;
    reg [`ASP_SHARED_W-1:0] oe_d;
    reg frame_d;
    reg [HWCFG_W-1:0] active_d;

    // All pin inputs pass two flip-flops
    assign sync_in = {i_interface_type_select, i_data_clock_source_select,
                      i_clock_edge_invert, i_frame_marker_polarity,
                      i_hw_config, i_shared_pin};

    asp_sync #(
        .W(SYNC_W)
    ) u_sync (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_async(sync_in),
        .o_sync(sync_out)
    );

    assign serial_s = sync_out[SYNC_W-1];
    assign slave_s = sync_out[SYNC_W-2];
    assign invert_s = sync_out[SYNC_W-3];
    assign polarity_s = sync_out[SYNC_W-4];
    assign hw_cfg_s = sync_out[`ASP_SHARED_W+HWCFG_W-1:`ASP_SHARED_W];
    assign pin_s = sync_out[`ASP_SHARED_W-1:0];
    assign cfg_src_s = pin_s[`ASP_PIN_CFGSRC];
    assign cfg_din_s = pin_s[`ASP_PIN_CFGDIN];
    assign cfg_clk_s = pin_s[`ASP_PIN_CFGCLK];
    assign cfg_sel_n_s = pin_s[`ASP_PIN_CFGSEL];

    // Active configuration clock edge and write qualification
    always @*
    begin
        if (invert_s)
            cfg_edge = cfg_clk_prev_q & ~cfg_clk_s;
        else
            cfg_edge = ~cfg_clk_prev_q & cfg_clk_s;
        cfg_write_en = serial_s & ~cfg_src_s & ~cfg_sel_n_s & cfg_edge
            & (settle_q == `ASP_SETTLE_CYCLES);
    end

    // Configuration clock edge history
    always @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
            cfg_clk_prev_q <= 1'b0;
        else
            cfg_clk_prev_q <= cfg_clk_s;
    end

    // Released pins still echo our own result bits until the synchroniser clears
    always @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
            settle_q <= 2'h0;
        else if (|o_shared_oe[`ASP_PIN_CFGSEL:`ASP_PIN_CFGSRC])
            settle_q <= 2'h0;
        else if (settle_q != `ASP_SETTLE_CYCLES)
            settle_q <= settle_q + 2'h1;
    end

    // Serial configuration register, shifted MSB first
    always @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
            cfg_q <= `ASP_CFG_RESET;
        else if (cfg_write_en)
            cfg_q <= {cfg_q[CFG_W-2:0], cfg_din_s};
    end

    // Slave read tracking and error detection
    always @*
    begin
        rderr_d = serial_s & slave_s & read_open_q & i_conversion_done;
    end

    always @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
            read_open_q <= 1'b0;
        else if (i_conversion_done)
            read_open_q <= 1'b0;
        else if (i_read_complete)
            read_open_q <= 1'b0;
        else if (i_read_start)
            read_open_q <= 1'b1;
    end

    // Frame marker level follows data validity and polarity
    always @*
    begin
        frame_d = i_read_valid ^ polarity_s;
    end

    // Settings source selection
    always @*
    begin
        active_d = {HWCFG_W{1'b0}};
        if (serial_s & ~cfg_src_s)
            active_d[CFG_W-1:0] = cfg_q;
        else
            active_d = hw_cfg_s;
    end

    // Shared pin drive and direction per mode
    always @*
    begin
        pin_d = {`ASP_SHARED_W{1'b0}};
        oe_d = {`ASP_SHARED_W{1'b0}};
        if (!serial_s)
        begin
            pin_d = i_result[`ASP_RESULT_HI:`ASP_RESULT_LO];
            oe_d = {`ASP_SHARED_W{1'b1}};
        end
        else if (!slave_s)
        begin
            pin_d[`ASP_PIN_FRAME] = frame_d;
            oe_d[`ASP_PIN_FRAME] = 1'b1;
        end
        else
        begin
            pin_d[`ASP_PIN_RDERR] = rderr_d;
            oe_d[`ASP_PIN_RDERR] = 1'b1;
        end
    end

    // Registered outputs
    always @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_shared_pin <= {`ASP_SHARED_W{1'b0}};
            o_shared_oe <= {`ASP_SHARED_W{1'b0}};
            o_serial_mode <= 1'b0;
            o_master_mode <= 1'b0;
            o_falling_edge_mode <= 1'b0;
            o_config_register <= `ASP_CFG_RESET;
            o_active_config <= {HWCFG_W{1'b0}};
            o_hw_config_active <= 1'b0;
            o_result_discard <= 1'b0;
        end
        else
        begin
            o_shared_pin <= pin_d;
            o_shared_oe <= oe_d;
            o_serial_mode <= serial_s;
            o_master_mode <= serial_s & ~slave_s;
            o_falling_edge_mode <= invert_s;
            o_config_register <= cfg_q;
            o_active_config <= active_d;
            o_hw_config_active <= ~serial_s | cfg_src_s;
            o_result_discard <= rderr_d;
        end
    end

endmodule // asp_serial_port

// >>> sim/asp_monitor.sv
`timescale 1ns/1ps
module asp_monitor (
    input wire i_clock,
    input wire i_reset,
    input wire [13:0] i_result,
    input wire i_read_valid,
    input wire i_conversion_done,
    input wire [5:0] o_shared_pin,
    input wire [5:0] o_shared_oe,
    input wire o_serial_mode,
    input wire o_master_mode,
    input wire [7:0] o_config_register,
    input wire [7:0] o_active_config,
    input wire o_hw_config_active,
    input wire o_result_discard
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    // Error flag stands one cycle
    sequence s_pulse;
        o_shared_pin[1] ##1 !o_result_discard;
    endsequence
    // Pin use per mode, frame marker, error pulse, config source
    par_pins_a: assert property (!$past(i_reset) && !o_serial_mode && !$past(o_serial_mode)
        |-> o_shared_oe == 6'h3f && o_shared_pin == $past(i_result[13:8])) else $error("pins");
    master_oe_a: assert property (o_master_mode |-> o_shared_oe == 6'h01) else $error("m oe");
    frame_edge_a: assert property (o_master_mode && $changed(i_read_valid) ##1 o_master_mode
        |-> $changed(o_shared_pin[0])) else $error("frame");
    slave_oe_a: assert property (o_serial_mode && !o_master_mode |-> o_shared_oe == 6'h02)
        else $error("s oe");
    err_pulse_a: assert property (o_result_discard |-> $past(i_conversion_done) ##0 s_pulse)
        else $error("pulse");
    no_err_a: assert property (o_master_mode && $past(o_master_mode) |-> !o_result_discard)
        else $error("m err");
    sw_cfg_a: assert property (o_serial_mode && !o_hw_config_active
        |-> o_active_config == o_config_register) else $error("sw cfg");
    hw_hold_a: assert property (o_hw_config_active && $past(o_hw_config_active)
        |-> $stable(o_config_register)) else $error("hw cfg");
endmodule // asp_monitor

bind asp_serial_port asp_monitor mon (.*);

// >>> sim/asp_host.sv
`timescale 1ns/1ps
module asp_host (
    output logic o_clock = 1'b0,
    output logic o_data = 1'b0,
    output logic o_select_n = 1'b1
);
    // One byte MSB first; clock idles at the level given by iv
    task send(input logic [7:0] v, input logic en, input logic iv);
        #3; // Off the system clock edge
        o_select_n = !en;
        o_clock = iv;
        for (int i = 7; i >= 0; i--)
        begin
            o_data = v[i];
            #80 o_clock = !iv;
            #80 o_clock = iv;
        end
        #80 o_select_n = 1'b1;
        o_data = !o_data;
    endtask
endmodule // asp_host

// >>> sim/tb_adc_serial_port_and_config.sv
`timescale 1ns/1ps
module tb_adc_serial_port_and_config;
    logic i_clock = 0, i_reset = 1, ser = 0, ext = 0, inv = 0, pol = 0, src = 0;
    logic rs = 0, rv = 0, cd = 0, rc = 0;
    logic [7:0] hw = 8'h00;
    logic [13:0] res = 14'h0000;
    logic [19:0] rows [3] = '{{14'h3f00, 6'h3f}, {14'h2aff, 6'h2a}, {14'h1500, 6'h15}};
    wire [5:0] po, oe, pin;
    wire sck, sdi, sel_n, dis;
    wire fem, mm, sm, hwa;
    wire [7:0] cfg, act;
    int failures = 0, checked = 0, cyc = 0;
    // Pin level from the DUT's oe alone: its drive where oe is set, the test's levels elsewhere
    assign pin = (oe & po) | (~oe & {sel_n, sck, sdi, src, cyc[1:0]});
    asp_serial_port dut (.i_clock(i_clock), .i_reset(i_reset), .i_interface_type_select(ser),
        .i_data_clock_source_select(ext), .i_clock_edge_invert(inv), .i_hw_config(hw),
        .i_frame_marker_polarity(pol), .i_shared_pin(pin), .i_result(res), .i_read_start(rs),
        .i_read_valid(rv), .i_read_complete(rc), .i_conversion_done(cd), .o_shared_pin(po),
        .o_shared_oe(oe), .o_serial_mode(sm), .o_master_mode(mm), .o_falling_edge_mode(fem),
        .o_config_register(cfg), .o_active_config(act), .o_hw_config_active(hwa),
        .o_result_discard(dis));
    asp_host host (.o_clock(sck), .o_data(sdi), .o_select_n(sel_n));
    always #5 i_clock = ~i_clock;
    // Cycle ceiling against hangs
    always @(posedge i_clock)
        if (++cyc > 6000)
        begin
            failures++;
            give_verdict;
        end
    task give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [13:0] g, input logic [13:0] e);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    // Open a read, optionally finish it, then end the conversion
    task conv(input logic fin);
        @(posedge i_clock) rs <= 1;
        tick(1);
        rs <= 0;
        if (fin)
        begin
            rc <= 1;
            tick(1);
            rc <= 0;
        end
        cd <= 1;
        tick(1);
        cd <= 0;
    endtask
    // Parallel rows, then master, slave and configuration cases
    initial
    begin
        tick(2);
        i_reset <= 0;
        #1 chk(cfg, 8'h00);
        foreach (rows[k])
        begin
            @(posedge i_clock) res <= rows[k][19:6];
            tick(2);
            #1 chk(po, rows[k][5:0]);
        end
        @(posedge i_clock) ser <= 1;
        for (int p = 0; p < 2; p++)
        begin
            @(posedge i_clock) pol <= p[0];
            tick(5);
            rv <= 1;
            tick(2);
            #1 chk(po[0], !p[0]);
            chk({sm, mm}, 2'b11);
            @(posedge i_clock) rv <= 0;
            tick(2);
            #1 chk(po[0], p[0]);
        end
        conv(1'b0);
        #1 chk({dis, mm}, 2'b01);
        @(posedge i_clock) ext <= 1;
        tick(5);
        conv(1'b0);
        #1 chk({dis, po[1]}, 2'b11);
        tick(1);
        #1 chk({dis, po[1]}, 2'b00);
        chk({sm, mm}, 2'b10);
        conv(1'b1);
        #1 chk({dis, po[1]}, 2'b00);
        for (int v = 0; v < 2; v++)
        begin
            @(posedge i_clock) inv <= v[0];
            tick(5);
            host.send(8'h5a ^ {8{v[0]}}, 1'b1, v[0]);
            tick(2);
            #1 chk(cfg, 8'h5a ^ {8{v[0]}});
            chk(act, 8'h5a ^ {8{v[0]}});
            chk({hwa, fem}, {1'b0, v[0]});
        end
        host.send(8'h33, 1'b0, 1'b1);
        tick(2);
        #1 chk(cfg, 8'ha5);
        @(posedge i_clock) src <= 1;
        hw <= 8'hc3;
        tick(5);
        host.send(8'h0f, 1'b1, 1'b1);
        tick(2);
        #1 chk(cfg, 8'ha5);
        chk(act, 8'hc3);
        chk(hwa, 1'b1);
        @(posedge i_clock) i_reset <= 1;
        tick(2);
        #1 chk(cfg, 8'h00);
        chk({po, oe}, 12'h000);
        @(posedge i_clock) i_reset <= 0;
        tick(6);
        #1 chk({hwa, act}, {1'b1, 8'hc3});
        chk(cfg, 8'h00);
        give_verdict;
    end
endmodule // tb_adc_serial_port_and_config
